// >>> srcl_pkg.sv
// Shared types and constants of the service request chain logic.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
package srcl_pkg;

    // ------------------------------------------------------------------
    // Levels
    // ------------------------------------------------------------------
    localparam int unsigned NUM_LEVELS = 3;
    localparam int unsigned LVL_RX     = 0;
    localparam int unsigned LVL_TX     = 1;
    localparam int unsigned LVL_MODEM  = 2;

    // ------------------------------------------------------------------
    // Receive queue
    // ------------------------------------------------------------------
    localparam int unsigned RXQ_DEPTH     = 8;
    localparam int unsigned RXQ_PTR_W     = 3;
    localparam int unsigned RXQ_CNT_W     = 4;
    localparam logic [3:0]  RXQ_CNT_RESET = 4'h0;
    localparam logic [2:0]  RXQ_PTR_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Reset values and synchroniser length
    // ------------------------------------------------------------------
    localparam logic [2:0]  LVL_RESET  = 3'h0;
    localparam logic        ACK_IDLE_N = 1'b1;
    localparam logic [2:0]  LINE_IDLE  = 3'h7;
    localparam int unsigned SYNC_LEN   = 2;

    // ------------------------------------------------------------------
    // Per-level controller states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        SRCL_IDLE    = 4'h1,
        SRCL_REQUEST = 4'h2,
        SRCL_FORWARD = 4'h4,
        SRCL_HOLD    = 4'h8
    } srcl_state_t;

    // Status of one received character.
    typedef struct packed {
        logic error;
        logic special;
        logic line_break;
        logic timeout;
    } srcl_rx_status_t;

endpackage : srcl_pkg

// >>> srcl_service_request.sv
// Service request chain logic for three request levels of a serial
// communications controller, with the receive queue that feeds level 0.
// Assumes the level comparator, software acknowledge reads and the core
// service flags come from logic on mclk; chain and line pins are async.
//
// What this block does
// - Three independent request levels, receive, transmit and modem, each with own output.
// - Four-state controller per level; idle goes to request, else forward on match.
// - Software acknowledge read acts like a chain acknowledge with a comparator match for that level.
// - Requesting drives the request line; acknowledge with match moves to holding.
// - Acknowledge without match while requesting waits, never forwarded down the chain.
// - Forwarding drives acknowledge-out, stays while acknowledge-in active, then idle.
// - Holding drives internal grant, returns idle once acknowledge-in goes away.
// - Per-level acknowledge-outs merge into the single chain acknowledge-out.
// - Chain acknowledge-out never glitches active while levels decide.
// - Each request line is watched both as driven and as seen outside.
// - At acknowledge cycle end, differing values mean another requester shares the line.
// - After a difference, own request waits until the external line goes inactive.
// - Receive level returns clean-data or exception vector, both at receive priority.
// - Receive requests follow arrival order: clean before exception before later clean.
// - Exception character: error, special match, line break or time-out condition.
// - Clean-data request when the queue reaches threshold holding clean data.
// - Clean-data request below threshold when clean data waits and timer expires.
// - Clean-data request below threshold when clean data waits ahead of new exception.
// - Queue keeps filling during a request; count rises for every clean byte taken in while the queue is not full.
// - Host may read fewer bytes; request is raised again while a condition holds.

`timescale 1ns/10ps
`default_nettype none

module srcl_service_request #(
    parameter int unsigned DEPTH = srcl_pkg::RXQ_DEPTH   // receive queue depth
) (
    input  wire logic                      mclk,            // 200 MHz clock
    input  wire logic                      sys_rst,         // sync reset
    input  wire logic                      chain_ack_in_n,  // chain ack pin
    input  wire logic [2:0]                level_match,     // comparator hits
    input  wire logic [2:0]                sw_ack_rd,       // ack reg reads
    input  wire logic [2:0]                ack_cycle_done,  // ack cycle end
    input  wire logic [2:0]                eos_wr,          // end of service
    input  wire logic                      tx_pending,      // tx service due
    input  wire logic                      modem_pending,   // modem change due
    input  wire logic [2:0]                req_line_in,     // shared lines, low
    input  wire logic                      rx_push,         // char arrives
    input  wire srcl_pkg::srcl_rx_status_t rx_status,       // its status
    input  wire logic                      rx_pop,          // host reads char
    input  wire logic                      rx_timer_expired,// data timer pulse
    input  wire logic [3:0]                rx_threshold,    // queue threshold
    output logic [2:0]                     req_line_out,    // line drive value
    output logic [2:0]                     req_line_oe,     // line drive enable
    output logic [2:0]                     grant,           // internal grant
    output logic                           chain_ack_out_n, // chain ack out
    output logic [2:0]                     in_service,      // context per level
    output logic                           rx_vec_exception,// rx vector subtype
    output logic [3:0]                     rx_clean_count,  // clean bytes held
    output logic                           rx_full          // queue full
);

    // ------------------------------------------------------------------
    // Next-state function of one level controller
    // ------------------------------------------------------------------
    function automatic srcl_pkg::srcl_state_t lvl_next(
        input srcl_pkg::srcl_state_t cur,
        input logic                  req,
        input logic                  ack,
        input logic                  match
    );
        srcl_pkg::srcl_state_t nxt;
        nxt = cur;
        unique case (cur)
            srcl_pkg::SRCL_IDLE: begin
                if (req) begin
                    nxt = srcl_pkg::SRCL_REQUEST;
                end else if (ack && match) begin
                    nxt = srcl_pkg::SRCL_FORWARD;
                end
            end
            srcl_pkg::SRCL_REQUEST: begin
                // A foreign acknowledge leaves us waiting here.
                if (ack && match) begin
                    nxt = srcl_pkg::SRCL_HOLD;
                end
            end
            srcl_pkg::SRCL_FORWARD: begin
                if (!ack) begin
                    nxt = srcl_pkg::SRCL_IDLE;
                end
            end
            srcl_pkg::SRCL_HOLD: begin
                if (!ack) begin
                    nxt = srcl_pkg::SRCL_IDLE;
                end
            end
            default: nxt = srcl_pkg::SRCL_IDLE;
        endcase
        return nxt;
    endfunction

    // Wrap-around increment of a queue pointer.
    function automatic logic [2:0] ptr_inc(input logic [2:0] p);
        return (p == 3'(DEPTH - 1)) ? 3'h0 : 3'(p + 3'h1);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [srcl_pkg::SYNC_LEN-1:0] ack_sync;
    logic [2:0]                    line_meta;
    logic [2:0]                    line_ext_n;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ack_sync   <= {srcl_pkg::SYNC_LEN{srcl_pkg::ACK_IDLE_N}};
            line_meta  <= srcl_pkg::LINE_IDLE;
            line_ext_n <= srcl_pkg::LINE_IDLE;
        end else begin
            ack_sync   <= {ack_sync[0], chain_ack_in_n};
            line_meta  <= req_line_in;
            line_ext_n <= line_meta;
        end
    end

    // Software reads act as a one-cycle acknowledge with a forced match.
    wire       ack_hw     = ~ack_sync[srcl_pkg::SYNC_LEN-1];
    wire       ack_any    = ack_hw | (|sw_ack_rd);
    wire [2:0] match_eff  = level_match | sw_ack_rd;

    // ------------------------------------------------------------------
    // Receive queue: one exception bit per entry, kept in arrival order
    // ------------------------------------------------------------------
    logic [DEPTH-1:0] q_exc;
    logic [2:0]       q_head;
    logic [2:0]       q_tail;
    logic [3:0]       q_fill;
    logic             timer_hit;

    wire rx_exc_in = rx_status.error | rx_status.special |
                     rx_status.line_break | rx_status.timeout;
    wire q_empty   = (q_fill == srcl_pkg::RXQ_CNT_RESET);
    wire q_full    = (q_fill == 4'(DEPTH));
    wire do_push   = rx_push & ~q_full;
    // The host may only drain inside a receive context.
    wire do_pop    = rx_pop & ~q_empty & in_service[srcl_pkg::LVL_RX];
    wire head_exc  = ~q_empty & q_exc[q_head];
    wire head_clean = ~q_empty & ~q_exc[q_head];

    // Exception present anywhere among held entries; with a clean head it
    // must sit behind clean data.
    logic exc_behind;
    always_comb begin
        exc_behind = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (4'(i) < q_fill) begin
                exc_behind = exc_behind | q_exc[3'(q_head + 3'(i))];
            end
        end
    end

    wire thr_hit   = head_clean & (rx_clean_count >= rx_threshold);
    wire tmr_cond  = head_clean & timer_hit;
    wire exc_cond  = head_clean & exc_behind;
    wire clean_req = thr_hit | tmr_cond | exc_cond;
    // Exceptions are only requested once the clean run ahead is gone.
    wire rx_pending = clean_req | head_exc;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            q_exc  <= '0;
            q_head <= srcl_pkg::RXQ_PTR_RESET;
            q_tail <= srcl_pkg::RXQ_PTR_RESET;
        end else begin
            if (do_push) begin
                q_exc[q_tail] <= rx_exc_in;
                q_tail        <= ptr_inc(q_tail);
            end
            if (do_pop) begin
                q_head <= ptr_inc(q_head);
            end
        end
    end

    wire       clean_in  = do_push & ~rx_exc_in;
    wire       clean_out = do_pop & ~q_exc[q_head];
    wire [3:0] next_fill = 4'(q_fill + 4'(do_push) - 4'(do_pop));
    wire [3:0] next_clean = 4'(rx_clean_count + 4'(clean_in) -
                               4'(clean_out));

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            q_fill         <= srcl_pkg::RXQ_CNT_RESET;
            rx_clean_count <= srcl_pkg::RXQ_CNT_RESET;
            rx_full        <= 1'b0;
        end else begin
            q_fill         <= next_fill;
            rx_clean_count <= next_clean;
            rx_full        <= (next_fill == 4'(DEPTH));
        end
    end

    // Level controller state, declared here because the receive logic
    // below looks at the receive level's transition.
    srcl_pkg::srcl_state_t st      [srcl_pkg::NUM_LEVELS];
    srcl_pkg::srcl_state_t next_st [srcl_pkg::NUM_LEVELS];

    // Vector subtype fixed when the receive level takes its acknowledge.
    wire rx_vec_next = head_exc;

    // The timer event is kept until clean data is taken into service; that grant
    // clears it, so after a partial drain only threshold or a waiting exception requests again.
    wire rx_granted = (st[srcl_pkg::LVL_RX] == srcl_pkg::SRCL_REQUEST) &&
                      (next_st[srcl_pkg::LVL_RX] == srcl_pkg::SRCL_HOLD);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            timer_hit <= 1'b0;
        end else if (rx_timer_expired && head_clean) begin
            timer_hit <= 1'b1;
        end else if (!head_clean || (rx_granted && !rx_vec_next)) begin
            timer_hit <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_vec_exception <= 1'b0;
        end else if (rx_granted) begin
            rx_vec_exception <= rx_vec_next;
        end
    end

    // ------------------------------------------------------------------
    // Fair share hold-off per shared line
    // ------------------------------------------------------------------
    logic [2:0] share_hold;
    // Own drive is released once granted; a line still low outside then
    // belongs to another requester.
    wire [2:0] line_int_n  = ~req_line_oe;
    wire [2:0] line_differ = line_int_n ^ line_ext_n;
    wire [2:0] next_hold   = (share_hold | (ack_cycle_done & line_differ))
                             & ~(share_hold & line_ext_n);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            share_hold <= srcl_pkg::LVL_RESET;
        end else begin
            share_hold <= next_hold;
        end
    end

    // ------------------------------------------------------------------
    // Service context per level
    // ------------------------------------------------------------------
    wire [2:0] core_pending = {modem_pending, tx_pending, rx_pending};
    // A level in context stays quiet until end-of-service pops it; the
    // pop reaches the request line two clocks later.
    wire [2:0] lvl_req = core_pending & ~in_service & ~share_hold;
    wire [2:0] next_ctx;

    // ------------------------------------------------------------------
    // Level controllers
    // ------------------------------------------------------------------
    logic [2:0]            next_oe;
    logic [2:0]            next_grant;
    logic [2:0]            next_pass;

    always_comb begin
        for (int l = 0; l < srcl_pkg::NUM_LEVELS; l++) begin
            next_st[l]    = lvl_next(st[l], lvl_req[l], ack_any,
                                     match_eff[l]);
            next_oe[l]    = (next_st[l] == srcl_pkg::SRCL_REQUEST);
            next_grant[l] = (next_st[l] == srcl_pkg::SRCL_HOLD);
            next_pass[l]  = (next_st[l] == srcl_pkg::SRCL_FORWARD);
        end
    end

    assign next_ctx = (in_service | (next_grant & ~grant)) & ~eos_wr;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int l = 0; l < srcl_pkg::NUM_LEVELS; l++) begin
                st[l] <= srcl_pkg::SRCL_IDLE;
            end
        end else begin
            for (int l = 0; l < srcl_pkg::NUM_LEVELS; l++) begin
                st[l] <= next_st[l];
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    // Forwarding is entered only on a positive match, and the merged
    // output is a flop, so no decision window can show on the chain.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            req_line_out    <= srcl_pkg::LVL_RESET;
            req_line_oe     <= srcl_pkg::LVL_RESET;
            grant           <= srcl_pkg::LVL_RESET;
            in_service      <= srcl_pkg::LVL_RESET;
            chain_ack_out_n <= srcl_pkg::ACK_IDLE_N;
        end else begin
            req_line_out    <= srcl_pkg::LVL_RESET;
            req_line_oe     <= next_oe;
            grant           <= next_grant;
            in_service      <= next_ctx;
            chain_ack_out_n <= ~(|next_pass);
        end
    end

endmodule : srcl_service_request

`default_nettype wire

// >>> srcl_peer_model.sv
// Host and peer model on the chain acknowledge pin and shared lines.
// Assumes the bench drives ack_go and peer_req just after mclk rises.
`timescale 1ns/10ps
`default_nettype none

module srcl_peer_model (
    input  wire logic       ack_go,         // host acknowledge active
    input  wire logic [2:0] peer_req,       // other devices requesting
    input  wire logic [2:0] req_line_oe,    // device drives line low
    output logic            chain_ack_in_n, // chain acknowledge pin
    output logic [2:0]      req_line_in     // resolved shared lines
);
    // ------------------------------------------------------------------
    // Wired lines
    // ------------------------------------------------------------------
    // The lines are pulled up, so a released line reads high.
    assign req_line_in    = ~(req_line_oe | peer_req);
    assign chain_ack_in_n = ~ack_go;
endmodule // srcl_peer_model

`default_nettype wire

// >>> srcl_service_request_chk.sv
// Concurrent checks on the ports of the service request chain logic.
// Assumes one clock, mclk, and synchronous active-high sys_rst.
`timescale 1ns/10ps
`default_nettype none

module srcl_service_request_chk (
    input wire logic                      mclk,             // clock
    input wire logic                      sys_rst,          // reset
    input wire logic                      chain_ack_in_n,   // ack pin
    input wire logic [2:0]                level_match,      // matches
    input wire logic [2:0]                sw_ack_rd,        // sw acks
    input wire logic [2:0]                eos_wr,           // eos writes
    input wire logic                      tx_pending,       // tx due
    input wire logic [2:0]                req_line_in,      // lines
    input wire logic                      rx_push,          // push
    input wire srcl_pkg::srcl_rx_status_t rx_status,        // status
    input wire logic                      rx_pop,           // pop
    input wire logic [2:0]                req_line_out,     // line value
    input wire logic [2:0]                req_line_oe,      // line enable
    input wire logic [2:0]                grant,            // grants
    input wire logic                      chain_ack_out_n,  // ack out
    input wire logic [2:0]                in_service,       // contexts
    input wire logic                      rx_vec_exception, // subtype
    input wire logic [3:0]                rx_clean_count,   // clean count
    input wire logic                      rx_full           // full
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking dc @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_line_drive_low: assert property (req_line_out == 3'h0)
        else $error("request line value not low");
    a_grant_from_req: assert property (
        (grant & ~$past(grant) & ~$past(req_line_oe)) == 3'h0)
        else $error("grant without prior request");
    a_grant_no_req: assert property ((grant & req_line_oe) == 3'h0)
        else $error("request kept while granted");
    a_fwd_on_match: assert property ($fell(chain_ack_out_n) |->
        ($past(level_match) | $past(level_match, 2) | $past(sw_ack_rd)
         | $past(sw_ack_rd, 2)) != 3'h0)
        else $error("ack passed on without match");
    a_ack_release: assert property (
        (chain_ack_in_n && sw_ack_rd == 3'h0) [*4] |=>
        chain_ack_out_n && grant == 3'h0)
        else $error("ack out or grant outlives ack in");
    a_no_pass_on: assert property (
        (level_match == 3'h0 && sw_ack_rd == 3'h0) [*3] |=> chain_ack_out_n)
        else $error("ack out active with no match");
    a_ctx_on_grant: assert property ($rose(grant[1]) |-> in_service[1])
        else $error("grant without service context");
    a_eos_reassert: assert property (
        eos_wr[1] && tx_pending && req_line_in[1] && chain_ack_in_n
        |-> ##2 req_line_oe[1])
        else $error("request not back two clocks after eos");
    a_count_clean: assert property (
        rx_push && !rx_full && rx_status == 4'h0 && !rx_pop |=>
        rx_clean_count == $past(rx_clean_count) + 4'h1)
        else $error("clean count not incremented");

    c_forward: cover property ($fell(chain_ack_out_n));
    c_rx_exception: cover property ($rose(grant[0]) && rx_vec_exception);
    c_sw_ack: cover property (sw_ack_rd[2] ##1 grant[2]);
endmodule // srcl_service_request_chk

bind srcl_service_request srcl_service_request_chk u_chk (.*);

`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the service request chain logic.
// Assumes the peer model resolves the shared lines and the ack pin.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic                      mclk, sys_rst, ack_go, tx_pending;
    logic                      modem_pending, rx_push, rx_pop;
    logic                      rx_timer_expired;
    logic [2:0]                level_match, sw_ack_rd, ack_cycle_done;
    logic [2:0]                eos_wr, peer_req;
    logic [3:0]                rx_threshold;
    srcl_pkg::srcl_rx_status_t rx_status;
    wire logic                 chain_ack_in_n, chain_ack_out_n;
    wire logic                 rx_vec_exception, rx_full;
    wire logic [2:0]           req_line_in, req_line_out, req_line_oe;
    wire logic [2:0]           grant, in_service;
    wire logic [3:0]           rx_clean_count;
    int                        fails, num_checks;

    srcl_service_request uut (.*);
    srcl_peer_model peer (.*);

    always #2.5 mclk = ~mclk;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp,
                           input string m);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic wait_oe(input int i);
        int k;
        k = 0;
        while (req_line_oe[i] !== 1'b1 && k < 12) begin
            tick(1);
            k++;
        end
        chk_bit(req_line_oe[i], 1'b1, "request not raised");
    endtask
    // The match is held until the ack has settled, as a real host would.
    task automatic ack_on(input logic [2:0] m);
        level_match = m;
        ack_go = 1'b1;
        tick(6);
    endtask
    task automatic ack_off(input logic [2:0] d);
        ack_cycle_done = d;
        tick(1);
        ack_cycle_done = 3'h0;
        ack_go = 1'b0;
        tick(6);
        level_match = 3'h0;
        tick(1);
    endtask
    task automatic eos(input int i);
        eos_wr[i] = 1'b1;
        tick(1);
        eos_wr = 3'h0;
    endtask
    task automatic push(input srcl_pkg::srcl_rx_status_t st);
        rx_status = st;
        rx_push = 1'b1;
        tick(1);
        rx_push = 1'b0;
    endtask
    task automatic pop;
        rx_pop = 1'b1;
        tick(1);
        rx_pop = 1'b0;
    endtask
    task automatic rx_serv(input logic v, input int n);
        ack_on(3'h1);
        chk_bit(grant[0], 1'b1, "no rx grant");
        chk_bit(rx_vec_exception, v, "wrong rx vector");
        repeat (n) pop();
        ack_off(3'h0);
        eos(0);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_forward;
        ack_on(3'h4);
        chk_bit(chain_ack_out_n, 1'b0, "ack not passed on");
        ack_off(3'h0);
        chk_bit(chain_ack_out_n, 1'b1, "ack out stuck");
    endtask
    task automatic t_tx_share;
        peer_req = 3'h2;
        tx_pending = 1'b1;
        wait_oe(1);
        ack_on(3'h0);
        chk_bit(req_line_oe[1], 1'b1, "request dropped");
        chk_bit(chain_ack_out_n, 1'b1, "foreign ack passed");
        ack_off(3'h0);
        ack_on(3'h2);
        chk_bit(grant[1], 1'b1, "no tx grant");
        chk_bit(req_line_oe[1], 1'b0, "request kept");
        ack_off(3'h2);
        chk_bit(grant[1], 1'b0, "grant kept");
        eos(1);
        tick(8);
        chk_bit(req_line_oe[1], 1'b0, "shared line ignored");
        peer_req = 3'h0;
        wait_oe(1);
        ack_on(3'h2);
        ack_off(3'h0);
        eos(1);
        wait_oe(1);
        tx_pending = 1'b0;
        ack_on(3'h2);
        ack_off(3'h0);
        eos(1);
    endtask
    task automatic t_sw_ack;
        modem_pending = 1'b1;
        wait_oe(2);
        sw_ack_rd = 3'h4;
        tick(1);
        sw_ack_rd = 3'h0;
        tick(3);
        chk_vec({1'b0, in_service}, 4'h4, "sw ack ignored");
        chk_bit(req_line_oe[2], 1'b0, "request kept");
        modem_pending = 1'b0;
        eos(2);
        tick(3);
        chk_vec({1'b0, in_service}, 4'h0, "context kept");
    endtask
    task automatic t_rx;
        push(4'h0);
        push(4'h0);
        tick(6);
        chk_bit(req_line_oe[0], 1'b0, "early rx request");
        push(4'h8);
        wait_oe(0);
        ack_on(3'h1);
        chk_bit(rx_vec_exception, 1'b0, "wrong rx vector");
        chk_vec(rx_clean_count, 4'h2, "clean count");
        push(4'h0);
        tick(1);
        chk_vec(rx_clean_count, 4'h3, "count during request");
        pop();
        ack_off(3'h0);
        eos(0);
        wait_oe(0);
        rx_serv(1'b0, 1);
        wait_oe(0);
        rx_serv(1'b1, 1);
        tick(6);
        chk_bit(req_line_oe[0], 1'b0, "rx request below threshold");
        rx_timer_expired = 1'b1;
        tick(1);
        rx_timer_expired = 1'b0;
        wait_oe(0);
        rx_serv(1'b0, 0);
        push(4'h0);
        push(4'h0);
        wait_oe(0);
        rx_serv(1'b0, 3);
        chk_vec(rx_clean_count, 4'h0, "queue not drained");
        repeat (8) push(4'h0);
        chk_bit(rx_full, 1'b1, "queue not full");
        wait_oe(0);
        rx_serv(1'b0, 8);
        chk_bit(rx_full, 1'b0, "queue still full");
    endtask
    task automatic t_exc_kinds;
        for (int b = 0; b < 4; b++) begin
            push(srcl_pkg::srcl_rx_status_t'(4'h1 << b));
            wait_oe(0);
            chk_vec(rx_clean_count, 4'h0, "exception counted");
            rx_serv(1'b1, 1);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        {mclk, ack_go, tx_pending, modem_pending} = 4'h0;
        {rx_push, rx_pop, rx_timer_expired} = 3'h0;
        {level_match, sw_ack_rd, ack_cycle_done} = 9'h000;
        {eos_wr, peer_req} = 6'h00;
        rx_threshold = 4'h3;
        rx_status = 4'h0;
        fails = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        tick(16);
        sys_rst = 1'b0;
        tick(3);
        chk_vec({1'b0, req_line_oe}, 4'h0, "request out of reset");
        chk_bit(chain_ack_out_n, 1'b1, "ack out after reset");
        t_forward();
        t_tx_share();
        t_sw_ack();
        t_rx();
        t_exc_kinds();
        stop_test();
    end

    // The whole run takes a few hundred cycles.
    initial begin
        #20000;
        fails++;
        stop_test();
    end
endmodule // testbench

`default_nettype wire
